// >>> src/host_bus_pkg.sv
package host_bus_pkg;

   localparam int ADDR_W   = 24;
   localparam int DATA_W   = 16;
   localparam int NUM_ENG  = 2;

   // register block: 64 words of 16 bits, 128 bytes
   localparam int REG_WORDS  = 64;
   localparam int REG_IDX_W  = 6;
   localparam int BASE_LSB   = 7;
   localparam int BASE_W     = ADDR_W - BASE_LSB;

   // engine numbering
   localparam int ENG_DRAW = 0;
   localparam int ENG_DISP = 1;

   // host status line codes, also driven back in master mode
   localparam logic [1:0] ST_READ  = 2'h1;
   localparam logic [1:0] ST_WRITE = 2'h2;
   localparam logic [1:0] ST_IDLE  = 2'h3;

   // word indices inside the register block
   localparam logic [REG_IDX_W-1:0] IDX_RELOC_LO = 6'h00;
   localparam logic [REG_IDX_W-1:0] IDX_RELOC_HI = 6'h01;
   localparam logic [NUM_ENG-1:0][REG_IDX_W-1:0] IDX_OPC = {6'h18, 6'h10};
   localparam logic [NUM_ENG-1:0][REG_IDX_W-1:0] IDX_ADR = {6'h19, 6'h11};

   // relocation word fields
   localparam int RELOC_SPACE_BIT = 0;
   localparam int RELOC_LO_LSB    = 7;
   localparam int RELOC_HI_W      = 8;

   // values after reset
   localparam logic [BASE_W-1:0] BASE_RST  = 17'h00000;
   localparam logic              SPACE_RST = 1'b0;

   typedef enum logic [2:0] {
      A_IDLE    = 3'h0,
      A_HOLD    = 3'h1,
      A_MCYC    = 3'h3,
      A_RELEASE = 3'h2,
      A_GM      = 3'h6,
      A_REG     = 3'h7,
      A_REGRD   = 3'h5,
      A_DONE    = 3'h4
   } arb_state_type;

endpackage : host_bus_pkg

// >>> src/reg_block_ram.sv
`timescale 1ns/1ps
`default_nettype none

module reg_block_ram #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 64,
   parameter int AW    = 6
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             we,
   input  wire logic [AW-1:0]    addr,
   input  wire logic [WIDTH-1:0] wdata,
   output var  logic [WIDTH-1:0] rdata_q
);

   // storage has no reset; reserved words simply read what was last written
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge sys_clk)
   begin
      if (we)
      begin
         mem[addr] <= wdata;
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         rdata_q <= '0;
      end
      else
      begin
         rdata_q <= mem[addr];
      end
   end

endmodule : reg_block_ram

`default_nettype wire

// >>> src/host_bus_unit.sv
`timescale 1ns/1ps
`default_nettype none

module host_bus_unit
(
   input  wire logic                          sys_clk,
   input  wire logic                          rst,
   // host slave side
   input  wire logic                          sync_mode,
   input  wire logic                          cs_n,
   input  wire logic [1:0]                    bus_status,
   input  wire logic                          rd_n,
   input  wire logic                          wr_n,
   input  wire logic                          mem_space,
   input  wire logic [host_bus_pkg::ADDR_W-1:0] addr,
   input  wire logic [host_bus_pkg::DATA_W-1:0] host_din,
   output var  logic [host_bus_pkg::DATA_W-1:0] host_dout_q,
   output var  logic                          host_doe_q,
   output var  logic                          ready_q,
   // system bus master side
   output var  logic                          hold_q,
   input  wire logic                          bus_grant_ack,
   input  wire logic                          sys_ready,
   input  wire logic [host_bus_pkg::DATA_W-1:0] sys_din,
   output var  logic [1:0]                    sys_status_q,
   output var  logic                          sys_oe_q,
   output var  logic                          sys_dout_oe_q,
   // shared cycle address and write data for both memories
   output var  logic [host_bus_pkg::ADDR_W-1:0] cyc_addr_q,
   output var  logic [host_bus_pkg::DATA_W-1:0] cyc_wdata_q,
   output var  logic                          cyc_we_q,
   // graphics memory controller side
   output var  logic                          gm_req_q,
   input  wire logic                          gm_done,
   input  wire logic [host_bus_pkg::DATA_W-1:0] gm_rdata,
   // drawing and display engines
   input  wire logic [host_bus_pkg::NUM_ENG-1:0] eng_req,
   input  wire logic [host_bus_pkg::NUM_ENG-1:0] eng_sys,
   input  wire logic [host_bus_pkg::NUM_ENG-1:0] eng_we,
   input  wire logic [host_bus_pkg::NUM_ENG-1:0][host_bus_pkg::ADDR_W-1:0]
                                              eng_addr,
   input  wire logic [host_bus_pkg::NUM_ENG-1:0][host_bus_pkg::DATA_W-1:0]
                                              eng_wdata,
   output var  logic [host_bus_pkg::NUM_ENG-1:0] eng_ack_q,
   output var  logic [host_bus_pkg::DATA_W-1:0] eng_rdata_q,
   // command launch
   output var  logic [host_bus_pkg::NUM_ENG-1:0] cmd_start_q,
   output var  logic [host_bus_pkg::NUM_ENG-1:0][host_bus_pkg::DATA_W-1:0]
                                              cmd_opcode_q,
   output var  logic [host_bus_pkg::NUM_ENG-1:0][host_bus_pkg::DATA_W-1:0]
                                              cmd_addr_q
);
   import host_bus_pkg::*;

   arb_state_type          state_q;
   arb_state_type          state_d;
   logic [BASE_W-1:0]      base_q;
   logic                   space_q;
   logic                   own_host_q;
   logic                   eng_sel_q;
   logic [DATA_W-1:0]      reg_rdata;

   // host cycle decode
   wire logic sync_rd = (bus_status == ST_READ);
   wire logic sync_wr = (bus_status == ST_WRITE);
   // the strobes replace the status lines when running asynchronously
   wire logic host_rd = sync_mode ? sync_rd : !rd_n;
   wire logic host_wr = sync_mode ? sync_wr : !wr_n;
   // a DMA controller is decoded on the same lines as the CPU
   wire logic host_req = !cs_n && (host_rd || host_wr);

   // block decode against the relocated base
   wire logic reg_hit = (addr[ADDR_W-1:BASE_LSB] == base_q)
                        && (mem_space == space_q);
   wire logic gm_hit  = mem_space && !reg_hit;

   // engine requests, masked in the cycle their ack is shown so that
   // a request still high after its ack is not served twice
   wire logic [NUM_ENG-1:0] eng_live = eng_req & ~eng_ack_q;
   wire logic eng_any  = |eng_live;
   // display engine first: its fetches feed the screen and cannot wait
   wire logic eng_pick = eng_live[ENG_DISP];
   wire logic accept   = (state_q == A_IDLE) && (host_req || eng_any);

   // register block access, host only
   wire logic [REG_IDX_W-1:0] reg_idx = cyc_addr_q[BASE_LSB-1:1];
   wire logic reg_wr = (state_q == A_REG) && cyc_we_q;

   // master cycle ends on the system ready of the external bus
   wire logic mcyc_end = (state_q == A_MCYC) && sys_ready;
   wire logic gm_end   = (state_q == A_GM) && gm_done;
   wire logic rel_end  = (state_q == A_RELEASE) && !bus_grant_ack;

   // one owner at a time: host and master paths share this machine, so a
   // host graphics cycle and an engine system cycle can never overlap
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         A_IDLE:
         begin
            if (host_req)
            begin
               if (reg_hit)
               begin
                  state_d = A_REG;
               end
               else if (gm_hit)
               begin
                  state_d = A_GM;
               end
               else
               begin
                  state_d = A_DONE;
               end
            end
            else if (eng_any)
            begin
               if (eng_sys[eng_pick])
               begin
                  state_d = A_HOLD;
               end
               else
               begin
                  state_d = A_GM;
               end
            end
         end
         A_REG:
         begin
            state_d = A_REGRD;
         end
         A_REGRD:
         begin
            state_d = A_DONE;
         end
         A_GM:
         begin
            if (gm_done)
            begin
               state_d = own_host_q ? A_DONE : A_IDLE;
            end
         end
         A_HOLD:
         begin
            if (bus_grant_ack)
            begin
               state_d = A_MCYC;
            end
         end
         A_MCYC:
         begin
            if (sys_ready)
            begin
               state_d = A_RELEASE;
            end
         end
         A_RELEASE:
         begin
            if (!bus_grant_ack)
            begin
               state_d = A_IDLE;
            end
         end
         A_DONE:
         begin
            if (!host_req)
            begin
               state_d = A_IDLE;
            end
         end
         default:
         begin
            state_d = A_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= A_IDLE;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // capture the winning cycle
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         own_host_q  <= 1'b0;
         eng_sel_q   <= 1'b0;
         cyc_addr_q  <= '0;
         cyc_wdata_q <= '0;
         cyc_we_q    <= 1'b0;
      end
      else if (accept)
      begin
         own_host_q  <= host_req;
         eng_sel_q   <= eng_pick;
         cyc_addr_q  <= host_req ? addr : eng_addr[eng_pick];
         cyc_wdata_q <= host_req ? host_din : eng_wdata[eng_pick];
         cyc_we_q    <= host_req ? host_wr : eng_we[eng_pick];
      end
   end

   // host answer: ready stands until the host drops its cycle
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         ready_q     <= 1'b0;
         host_doe_q  <= 1'b0;
         host_dout_q <= '0;
      end
      else
      begin
         ready_q    <= (state_d == A_DONE);
         host_doe_q <= (state_d == A_DONE) && host_rd;
         if (state_q == A_REGRD)
         begin
            // reserved words return whatever the array holds
            host_dout_q <= reg_rdata;
         end
         else if (gm_end && own_host_q)
         begin
            host_dout_q <= gm_rdata;
         end
         else if (accept && host_req)
         begin
            host_dout_q <= '0;
         end
      end
   end

   // graphics memory request stands until the controller reports done
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         gm_req_q <= 1'b0;
      end
      else
      begin
         gm_req_q <= (state_d == A_GM) && !gm_done;
      end
   end

   // master mode: request, wait for grant, run one cycle, release
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         hold_q        <= 1'b0;
         sys_oe_q      <= 1'b0;
         sys_dout_oe_q <= 1'b0;
         sys_status_q  <= ST_IDLE;
      end
      else
      begin
         hold_q <= (state_d == A_HOLD) || (state_d == A_MCYC);
         sys_oe_q      <= (state_d == A_MCYC);
         sys_dout_oe_q <= (state_d == A_MCYC) && cyc_we_q;
         if (state_d == A_MCYC)
         begin
            sys_status_q <= cyc_we_q ? ST_WRITE : ST_READ;
         end
         else
         begin
            sys_status_q <= ST_IDLE;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         eng_rdata_q <= '0;
      end
      else if (mcyc_end)
      begin
         eng_rdata_q <= sys_din;
      end
      else if (gm_end && !own_host_q)
      begin
         eng_rdata_q <= gm_rdata;
      end
   end

   // relocation of the register block
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         base_q  <= BASE_RST;
         space_q <= SPACE_RST;
      end
      else if (reg_wr && (reg_idx == IDX_RELOC_LO))
      begin
         base_q[ADDR_W-RELOC_HI_W-BASE_LSB-1:0] <=
            cyc_wdata_q[DATA_W-1:RELOC_LO_LSB];
         space_q <= cyc_wdata_q[RELOC_SPACE_BIT];
      end
      else if (reg_wr && (reg_idx == IDX_RELOC_HI))
      begin
         base_q[BASE_W-1:BASE_W-RELOC_HI_W] <=
            cyc_wdata_q[RELOC_HI_W-1:0];
      end
   end

   // per engine: ack and command launch
   for (genvar e = 0; e < NUM_ENG; e++)
   begin : g_eng
      wire logic mine = (eng_sel_q == 1'(e)) && !own_host_q;

      always_ff @(posedge sys_clk or posedge rst)
      begin
         if (rst)
         begin
            eng_ack_q[e]    <= 1'b0;
            cmd_start_q[e]  <= 1'b0;
            cmd_opcode_q[e] <= '0;
            cmd_addr_q[e]   <= '0;
         end
         else
         begin
            eng_ack_q[e]   <= mine && (gm_end || rel_end);
            cmd_start_q[e] <= reg_wr && (reg_idx == IDX_OPC[e]);
            if (reg_wr && (reg_idx == IDX_OPC[e]))
            begin
               cmd_opcode_q[e] <= cyc_wdata_q;
            end
            if (reg_wr && (reg_idx == IDX_ADR[e]))
            begin
               cmd_addr_q[e] <= cyc_wdata_q;
            end
         end
      end
   end

   // register array; engines have no port onto it
   reg_block_ram #(
      .WIDTH (DATA_W),
      .DEPTH (REG_WORDS),
      .AW    (REG_IDX_W)
   ) u_regs (
      .sys_clk (sys_clk),
      .rst     (rst),
      .we      (reg_wr),
      .addr    (reg_idx),
      .wdata   (cyc_wdata_q),
      .rdata_q (reg_rdata)
   );

endmodule : host_bus_unit

`default_nettype wire

// >>> sim/host_bus_unit_properties.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus_unit_properties
   import host_bus_pkg::*;
(
   input wire logic               sys_clk,
   input wire logic               rst,
   input wire logic               cs_n,
   input wire logic               ready_q,
   input wire logic               host_doe_q,
   input wire logic               hold_q,
   input wire logic               bus_grant_ack,
   input wire logic               sys_ready,
   input wire logic [1:0]         sys_status_q,
   input wire logic               sys_oe_q,
   input wire logic               sys_dout_oe_q,
   input wire logic               cyc_we_q,
   input wire logic               gm_req_q,
   input wire logic               gm_done,
   input wire logic [NUM_ENG-1:0] eng_ack_q,
   input wire logic [NUM_ENG-1:0] cmd_start_q
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_grant_first: assert property (
      $rose(sys_oe_q) |-> $past(bus_grant_ack)) else $error("early drive");
   a_drive_needs_hold: assert property (
      sys_oe_q |-> hold_q) else $error("bus driven without request");
   a_wdata_drive: assert property (
      sys_dout_oe_q |-> sys_oe_q && cyc_we_q) else $error("stray data drive");
   a_status_style: assert property (
      sys_status_q == (!sys_oe_q ? ST_IDLE : cyc_we_q ? ST_WRITE : ST_READ))
      else $error("status code wrong");
   a_release_bus: assert property (
      sys_oe_q && sys_ready |=> !hold_q && !sys_oe_q)
      else $error("bus not released");
   a_no_cross: assert property (
      !(gm_req_q && hold_q)) else $error("cross accesses overlap");
   a_one_grant: assert property (
      $onehot0(eng_ack_q)) else $error("two engines acked");
   a_gm_answer: assert property (
      gm_req_q && gm_done |=> !gm_req_q && (ready_q != (|eng_ack_q)))
      else $error("graphics memory answer wrong");
   a_ready_on_cs: assert property (
      $rose(ready_q) |-> !cs_n) else $error("ready without select");
   a_ready_drop: assert property (
      ready_q && cs_n |=> !ready_q) else $error("ready stuck");
   a_cmd_ready: assert property (
      |cmd_start_q |=> ready_q && !(|cmd_start_q))
      else $error("launch pulse wrong");
   a_doe_ready: assert property (
      host_doe_q |-> ready_q) else $error("data driven outside ready");
   c_master: cover property (sys_oe_q && sys_ready);
   c_launch: cover property (|cmd_start_q);
   c_gm: cover property (gm_req_q && gm_done);
endmodule : host_bus_unit_properties

bind host_bus_unit host_bus_unit_properties u_props (.sys_clk, .rst, .cs_n,
   .ready_q, .host_doe_q, .hold_q, .bus_grant_ack, .sys_ready, .sys_status_q,
   .sys_oe_q, .sys_dout_oe_q, .cyc_we_q, .gm_req_q, .gm_done, .eng_ack_q,
   .cmd_start_q);
`default_nettype wire

// >>> sim/sys_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module sys_bus_model
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic [2:0]  lat,
   input  wire logic        hold_q,
   input  wire logic        sys_oe_q,
   input  wire logic        gm_req_q,
   output var  logic        bus_grant_ack,
   output var  logic        sys_ready,
   output var  logic        gm_done,
   output var  logic [15:0] sys_din,
   output var  logic [15:0] gm_rdata
);
   logic [2:0] cnt_q;
   logic       wait_c;
   logic       fire_c;
   // one wait counter serves grant, bus ready and memory done: never overlap
   assign wait_c = (hold_q && !bus_grant_ack) || (sys_oe_q && !sys_ready)
                   || (gm_req_q && !gm_done);
   assign fire_c = wait_c && (cnt_q == lat);
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_q <= 3'h0;
         bus_grant_ack <= 1'b0;
         sys_ready <= 1'b0;
         gm_done <= 1'b0;
         sys_din <= 16'h1357;
         gm_rdata <= 16'h2468;
      end
      else
      begin
         cnt_q <= (wait_c && !fire_c) ? cnt_q + 3'h1 : 3'h0;
         bus_grant_ack <= hold_q && (bus_grant_ack || fire_c);
         sys_ready <= fire_c && sys_oe_q && !sys_ready;
         gm_done <= fire_c && gm_req_q && !gm_done;
         // data moves every cycle so a late or early sample is seen
         sys_din <= sys_din + 16'h9E37;
         gm_rdata <= gm_rdata + 16'h7F4B;
      end
   end
endmodule : sys_bus_model
`default_nettype wire

// >>> sim/tb_graphics_host_bus_interface.sv
`timescale 1ns/1ps
`default_nettype none
module tb_graphics_host_bus_interface;
   import host_bus_pkg::*;
   logic                 sys_clk = 1'b0, rst = 1'b1, sync_mode = 1'b1;
   logic                 cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
   logic                 mem_space = 1'b0, space = 1'b0;
   logic [1:0]           bus_status = ST_IDLE, sys_status_q;
   logic [ADDR_W-1:0]    addr = '0, base = '0, cyc_addr_q, last_a;
   logic [DATA_W-1:0]    host_din = '0, host_dout_q, sys_din, gm_rdata;
   logic [DATA_W-1:0]    cyc_wdata_q, eng_rdata_q, last_sys, last_gm, last_w;
   logic                 host_doe_q, ready_q, hold_q, bus_grant_ack;
   logic                 sys_ready, sys_oe_q, sys_dout_oe_q, cyc_we_q;
   logic                 gm_req_q, gm_done;
   logic [2:0]           lat = 3'h0;
   logic [NUM_ENG-1:0]   eng_req = '0, eng_sys = '0, eng_we = '0;
   logic [NUM_ENG-1:0]   eng_ack_q, cmd_start_q;
   logic [NUM_ENG-1:0][ADDR_W-1:0] eng_addr = '0;
   logic [NUM_ENG-1:0][DATA_W-1:0] eng_wdata = '0, cmd_opcode_q, cmd_addr_q;
   logic [DATA_W-1:0]    opc_exp [NUM_ENG];
   int                   bad_count = 0, num_checks = 0, cycles = 0;
   int                   seed = 32762;
   int                   start_n [NUM_ENG] = '{0, 0};

   host_bus_unit u_dut (.sys_clk, .rst, .sync_mode, .cs_n, .bus_status,
      .rd_n, .wr_n, .mem_space, .addr, .host_din, .host_dout_q, .host_doe_q,
      .ready_q, .hold_q, .bus_grant_ack, .sys_ready, .sys_din, .sys_status_q,
      .sys_oe_q, .sys_dout_oe_q, .cyc_addr_q, .cyc_wdata_q, .cyc_we_q,
      .gm_req_q, .gm_done, .gm_rdata, .eng_req, .eng_sys, .eng_we, .eng_addr,
      .eng_wdata, .eng_ack_q, .eng_rdata_q, .cmd_start_q, .cmd_opcode_q,
      .cmd_addr_q);
   sys_bus_model u_bus (.sys_clk, .rst, .lat, .hold_q, .sys_oe_q, .gm_req_q,
      .bus_grant_ack, .sys_ready, .gm_done, .sys_din, .gm_rdata);

   always #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (sys_ready) last_sys = sys_din;
   always @(posedge sys_clk) if (gm_done) last_gm = gm_rdata;
   always @(posedge sys_clk)
   begin
      if (gm_req_q || sys_oe_q) last_a = cyc_addr_q;
      if (gm_req_q || sys_oe_q) last_w = cyc_wdata_q;
      for (int e = 0; e < NUM_ENG; e++)
         if (cmd_start_q[e] === 1'b1) start_n[e]++;
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      if (bad_count == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : print_verdict

   task automatic check(input string nm, input logic [23:0] exp, got);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : check

   function automatic logic [23:0] reg_a(logic [23:0] b, logic [5:0] idx);
      return b + {17'h0, idx, 1'b0};
   endfunction : reg_a

   // same cycle shape whether a processor or a dma controller drives it
   task automatic host_cyc(input logic we, sp, logic [23:0] a,
      logic [15:0] d, output logic [15:0] q, output int k);
      @(negedge sys_clk);
      sync_mode = 1'($random(seed));
      mem_space = sp;
      addr = a;
      host_din = d;
      cs_n = 1'b0;
      bus_status = sync_mode ? (we ? ST_WRITE : ST_READ) : ST_IDLE;
      rd_n = sync_mode | we;
      wr_n = sync_mode | !we;
      k = 0;
      do
      begin
         @(negedge sys_clk);
         k++;
      end
      while (ready_q !== 1'b1 && k < 300);
      q = host_dout_q;
      check("ready", 1'b1, ready_q);
      @(negedge sys_clk);
      cs_n = 1'b1;
      bus_status = ST_IDLE;
      rd_n = 1'b1;
      wr_n = 1'b1;
   endtask : host_cyc

   task automatic reg_rw(input logic we, logic [5:0] idx, logic [15:0] d,
      output logic [15:0] q);
      int k;
      host_cyc(we, space, reg_a(base, idx), d, q, k);
      check("register latency", 3, k);
   endtask : reg_rw

   task automatic eng_op(input int e, logic s, w, logic [23:0] a,
      logic [15:0] d, output logic [15:0] q);
      int k;
      @(negedge sys_clk);
      eng_sys[e] = s;
      eng_we[e] = w;
      eng_addr[e] = a;
      eng_wdata[e] = d;
      eng_req[e] = 1'b1;
      k = 0;
      do
      begin
         @(negedge sys_clk);
         k++;
      end
      while (eng_ack_q[e] !== 1'b1 && k < 300);
      q = eng_rdata_q;
      check("engine ack", 1'b1, eng_ack_q[e]);
      eng_req[e] = 1'b0;
   endtask : eng_op

   initial
   begin
      logic [15:0] q, d, d2;
      logic [23:0] a;
      int          k, e;
      repeat (20) @(posedge sys_clk);
      @(negedge sys_clk);
      rst = 1'b0;
      check("status idle", ST_IDLE, sys_status_q);
      check("no request", 1'b0, hold_q);
      for (int i = 0; i < 6; i++)
      begin
         e = i % NUM_ENG;
         d = $random(seed);
         d2 = $random(seed);
         opc_exp[e] = d;
         reg_rw(1'b1, IDX_ADR[e], d2, q);
         reg_rw(1'b1, IDX_OPC[e], d, q);
         check("opcode out", d, cmd_opcode_q[e]);
         check("address out", d2, cmd_addr_q[e]);
         check("launch count", i / 2 + 1, start_n[e]);
         reg_rw(1'b0, IDX_OPC[e], 16'h0000, q);
         check("opcode read", d, q);
      end
      reg_rw(1'b1, 6'h3F, 16'h0000, q);
      reg_rw(1'b0, 6'h3F, 16'h0000, q);
      d = {9'($random(seed)) | 9'h001, 7'h01};
      reg_rw(1'b1, IDX_RELOC_LO, d, q);
      base = {8'h00, d[15:7], 7'h00};
      space = 1'b1;
      reg_rw(1'b0, IDX_OPC[ENG_DISP], 16'h0000, q);
      check("moved block", opc_exp[ENG_DISP], q);
      host_cyc(1'b0, 1'b0, reg_a(24'h0, IDX_OPC[0]), 16'h0, q, k);
      check("io miss latency", 1, k);
      check("io miss data", 16'h0000, q);
      for (int i = 0; i < 6; i++)
      begin
         lat = 3'($random(seed));
         a = (i == 0) ? base + 24'h80 : 24'($random(seed)) | 24'h800000;
         a[0] = 1'b0;
         d = $random(seed);
         host_cyc(i[0], 1'b1, a, d, q, k);
         check("gm address", a, last_a);
         check("gm data", i[0] ? d : last_gm, i[0] ? last_w : q);
         check("gm wait", 1'b1, k > lat + 2);
      end
      for (int i = 0; i < 8; i++)
      begin
         lat = 3'($random(seed));
         a = (i == 0) ? reg_a(base, IDX_OPC[0])
                      : 24'($random(seed)) & 24'hFFFFFE;
         d = $random(seed);
         eng_op(i % 2, i[1], i[2], a, d, q);
         check("engine address", a, last_a);
         check("engine data", i[2] ? d : (i[1] ? last_sys : last_gm),
            i[2] ? last_w : q);
      end
      lat = 3'h2;
      fork
         host_cyc(1'b0, 1'b1, 24'h800010, 16'h0000, q, k);
         eng_op(ENG_DRAW, 1'b1, 1'b0, 24'h000200, 16'h0000, d);
         eng_op(ENG_DISP, 1'b1, 1'b1, 24'h000300, 16'hBEEF, d2);
      join
      print_verdict();
   end
endmodule : tb_graphics_host_bus_interface
`default_nettype wire
